// ### core/pid_pkg.sv
// Constants, register map and carrier types of the heater control law
package pid_pkg;
	// Clock and sample timing
	localparam int unsigned CLK_FREQ_HZ = 200000000;
	localparam int unsigned SAMPLE_TIME_MS = 100;
	localparam int unsigned SAMPLE_CYCLES = SAMPLE_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned MS_PER_S = 1000;
	// Integral setting is a rate: 1000 divided by the time constant in seconds
	localparam int unsigned INTEG_RATE_SCALE = 1000;
	// Gain is unsigned with eight fraction bits
	localparam int unsigned GAIN_SHIFT = 8;
	// Temperatures are signed milli-kelvin, heater level in 0.01 % steps
	localparam int TEMP_W = 16;
	localparam int HEAT_W = 14;
	localparam logic [13:0] HEAT_FULL = 14'h2710;
	localparam int ACC_W = 48;
	localparam logic [47:0] ACC_LIMIT_DEF = 48'h0100_0000_0000;
	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SETPOINT_OFS = 8'h04;
	localparam logic [7:0] GAIN_OFS = 8'h08;
	localparam logic [7:0] INTEG_RATE_OFS = 8'h0C;
	localparam logic [7:0] DERIV_TIME_OFS = 8'h10;
	localparam logic [7:0] MANUAL_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [7:0] HEAT_OFS = 8'h1C;
	localparam logic [7:0] ERROR_OFS = 8'h20;
	// Field positions
	localparam int CTRL_CLOSED_BIT = 0;
	localparam int CTRL_ADD_MANUAL_BIT = 1;
	localparam int STATUS_SAT_BIT = 0;
	localparam int STATUS_ACTIVE_BIT = 1;
	// Reset values
	localparam logic [15:0] SETTING_RESET = 16'h0000;
	localparam logic [13:0] MANUAL_RESET = 14'h0000;

	typedef struct packed {
		logic closed;
		logic add_manual;
	} ctrl_type;

	typedef struct packed {
		logic saturated;
		logic [13:0] level;
	} heat_out_type;

	localparam ctrl_type CTRL_RESET = '{closed: 1'b0, add_manual: 1'b0};
endpackage : pid_pkg

// ### core/sample_tick_divider.sv
// Divider that issues the one-cycle control sample tick
`timescale 1ns/10ps
module sample_tick_divider #(
	parameter int unsigned CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	output logic tick_o
);
	localparam int CNT_W = $clog2(CYCLES);

	logic [CNT_W-1:0] count_reg;
	logic tick_reg;
	wire wrap_w = count_reg == CNT_W'(CYCLES - 1);

	if (CYCLES < 4) begin : g_check
		$error("sample_tick_divider: CYCLES must be at least 4");
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= wrap_w ? '0 : count_reg + 1'b1;
			tick_reg <= wrap_w;
		end
	end

	assign tick_o = tick_reg;
endmodule : sample_tick_divider

// ### core/pid_heater_control_law.sv
// Heater control law: error, PID terms, manual offset and output limit
//
// How it works
// R1 - Error is setpoint minus feedback; output is gain times error plus terms.
// R2 - Closed-loop action only while gain is above zero.
// R3 - Proportional part is gain times error; zero error alone gives zero.
// R4 - Integral part is gain times rate times summed error; holds at zero error.
// R5 - Integral setting is a rate: 1000 over the time constant in seconds.
// R6 - Derivative part is gain times setting times error slope, setting in seconds.
// R7 - Open loop ignores feedback and drives the manual level.
// R8 - Closed loop may add the manual level as an offset.
// R9 - Manual level is percent of full scale of the selected range.
// R10 - Heater command limited to 0..100 %, saturation reported as 100 %.
// R11 - Law runs once per sample tick: sum errors, difference successive errors.
// R12 - Zero integral or derivative setting disables it; zero manual adds nothing.
`timescale 1ns/10ps
module pid_heater_control_law #(
	parameter int unsigned TICK_CYCLES = pid_pkg::SAMPLE_CYCLES,
	parameter logic [47:0] ACC_LIMIT = pid_pkg::ACC_LIMIT_DEF
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [pid_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic signed [pid_pkg::TEMP_W-1:0] fb_temp_i,
	output pid_pkg::heat_out_type heat_o
);
	import pid_pkg::*;

	if (ACC_LIMIT == '0 || ACC_LIMIT[47]) begin : g_check
		$error("pid_heater_control_law: ACC_LIMIT must be positive");
	end

	if (TICK_CYCLES < 4) begin : g_tick_check
		$error("pid_heater_control_law: TICK_CYCLES must be at least 4");
	end

	localparam logic signed [47:0] SAMPLE_MS_S = 48'(SAMPLE_TIME_MS);
	localparam logic signed [47:0] MS_PER_S_S = 48'(MS_PER_S);
	localparam logic signed [47:0] INTEG_DIV_S = 48'(INTEG_RATE_SCALE * MS_PER_S);
	localparam logic signed [48:0] ACC_HI = 49'(ACC_LIMIT);
	localparam logic signed [48:0] ACC_LO = -49'(ACC_LIMIT);

	// Settings
	ctrl_type ctrl_reg;
	logic signed [15:0] setpoint_reg;
	logic [15:0] gain_reg;
	logic [15:0] integ_rate_reg;
	logic [15:0] deriv_time_reg;
	logic [13:0] manual_reg;

	// Bus slave state
	logic ready_reg;
	logic slverr_reg;
	logic [31:0] rdata_reg;

	// Data path state
	logic tick_w;
	logic tick_d1_reg;
	logic tick_d2_reg;
	logic signed [16:0] err_reg;
	logic signed [16:0] prev_err_reg;
	logic signed [47:0] integ_reg;
	logic signed [15:0] pid_reg;
	heat_out_type heat_reg;

	// ---------------- APB slave ----------------
	wire setup_w = psel_i && !penable_i;
	wire access_w = psel_i && penable_i && ready_reg;
	wire hit_ctrl_w = paddr_i == CTRL_OFS;
	wire hit_sp_w = paddr_i == SETPOINT_OFS;
	wire hit_gain_w = paddr_i == GAIN_OFS;
	wire hit_rate_w = paddr_i == INTEG_RATE_OFS;
	wire hit_deriv_w = paddr_i == DERIV_TIME_OFS;
	wire hit_man_w = paddr_i == MANUAL_OFS;
	wire hit_stat_w = paddr_i == STATUS_OFS;
	wire hit_heat_w = paddr_i == HEAT_OFS;
	wire hit_err_w = paddr_i == ERROR_OFS;
	wire hit_ro_w = hit_stat_w || hit_heat_w || hit_err_w;
	wire hit_rw_w = hit_ctrl_w || hit_sp_w || hit_gain_w || hit_rate_w || hit_deriv_w || hit_man_w;
	wire mapped_w = hit_ro_w || hit_rw_w;
	wire wr_w = access_w && pwrite_i;
	wire loop_active_w = ctrl_reg.closed && (gain_reg != 16'h0000);

	wire [31:0] ctrl_rd_w = {30'h0, ctrl_reg.add_manual, ctrl_reg.closed};
	wire [31:0] stat_rd_w = {30'h0, loop_active_w, heat_reg.saturated};
	wire [31:0] rdata_next = hit_ctrl_w ? ctrl_rd_w :
		hit_sp_w ? {{16{setpoint_reg[15]}}, setpoint_reg} :
		hit_gain_w ? {16'h0, gain_reg} :
		hit_rate_w ? {16'h0, integ_rate_reg} :
		hit_deriv_w ? {16'h0, deriv_time_reg} :
		hit_man_w ? {18'h0, manual_reg} :
		hit_stat_w ? stat_rd_w :
		hit_heat_w ? {18'h0, heat_reg.level} :
		hit_err_w ? {{15{err_reg[16]}}, err_reg} : 32'h0000_0000;

	// Answer in the first access cycle; unmapped addresses get an error
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ready_reg <= 1'b0;
			slverr_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ready_reg <= setup_w;
			if (setup_w) begin
				slverr_reg <= !mapped_w;
				rdata_reg <= pwrite_i ? 32'h0000_0000 : rdata_next;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_reg <= CTRL_RESET;
			setpoint_reg <= SETTING_RESET;
			gain_reg <= SETTING_RESET;
		end else if (wr_w) begin
			if (hit_ctrl_w) begin
				ctrl_reg.closed <= pwdata_i[CTRL_CLOSED_BIT];
				ctrl_reg.add_manual <= pwdata_i[CTRL_ADD_MANUAL_BIT];
			end
			if (hit_sp_w) begin
				setpoint_reg <= pwdata_i[15:0];
			end
			if (hit_gain_w) begin
				gain_reg <= pwdata_i[15:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			integ_rate_reg <= SETTING_RESET;
			deriv_time_reg <= SETTING_RESET;
			manual_reg <= MANUAL_RESET;
		end else if (wr_w) begin
			if (hit_rate_w) begin
				integ_rate_reg <= pwdata_i[15:0];
			end
			if (hit_deriv_w) begin
				deriv_time_reg <= pwdata_i[15:0];
			end
			if (hit_man_w) begin
				manual_reg <= pwdata_i[13:0];
			end
		end
	end

	assign prdata_o = rdata_reg;
	assign pready_o = ready_reg;
	assign pslverr_o = slverr_reg;

	// ---------------- Sample tick ----------------
	sample_tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.tick_o(tick_w)
	);

	// ---------------- Stage 0: error and integrator ----------------
	wire signed [16:0] err_now_w = 17'(setpoint_reg) - 17'(fb_temp_i); // [R1]
	// Error times rate times sample time; scaled back by 1000 * 1000 later
	wire signed [47:0] inc_w = 48'(err_now_w) * 48'($signed({1'b0, integ_rate_reg})) * SAMPLE_MS_S; // [R5]
	wire signed [48:0] acc_sum_w = 49'(integ_reg) + 49'(inc_w);
	wire signed [48:0] acc_lim_w = (acc_sum_w > ACC_HI) ? ACC_HI :
		(acc_sum_w < ACC_LO) ? ACC_LO : acc_sum_w;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			err_reg <= '0;
			prev_err_reg <= '0;
		end else if (tick_w) begin
			err_reg <= err_now_w; // [R1]
			prev_err_reg <= err_reg; // [R11]
		end
	end

	// Integrator is cleared while the loop is not acting, limited against windup
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			integ_reg <= '0;
		end else if (tick_w) begin
			integ_reg <= loop_active_w ? acc_lim_w[47:0] : '0; // [R2] [R4] [R11]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tick_d1_reg <= 1'b0;
			tick_d2_reg <= 1'b0;
		end else begin
			tick_d1_reg <= tick_w;
			tick_d2_reg <= tick_d1_reg;
		end
	end

	// ---------------- Stage 1: PID sum and gain ----------------
	wire signed [17:0] de_w = 18'(err_reg) - 18'(prev_err_reg); // [R11]
	// A zero rate drops the term at once, even with a charged integrator
	wire signed [47:0] iterm_w = (integ_rate_reg == 16'h0000) ? 48'sh0 :
		integ_reg / INTEG_DIV_S; // [R4] [R5] [R12]
	wire signed [47:0] dterm_w = (48'(de_w) * 48'($signed({1'b0, deriv_time_reg})) * MS_PER_S_S)
		/ SAMPLE_MS_S; // [R6] [R12]
	wire signed [47:0] sum_w = 48'(err_reg) + iterm_w + dterm_w; // [R1]
	wire signed [64:0] prod_w = 65'(sum_w) * 65'($signed({1'b0, gain_reg})); // [R3]
	wire signed [64:0] prod_sh_w = prod_w >>> GAIN_SHIFT;
	wire signed [15:0] pid_next = (gain_reg == 16'h0000) ? 16'sh0000 : // [R2]
		(prod_sh_w > 65'sh7FFF) ? 16'sh7FFF :
		(prod_sh_w < -65'sh8000) ? 16'sh8000 : prod_sh_w[15:0];

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pid_reg <= '0;
		end else if (tick_d1_reg) begin
			pid_reg <= pid_next;
		end
	end

	// ---------------- Stage 2: mode, offset and limit ----------------
	wire [13:0] man_w = (manual_reg > HEAT_FULL) ? HEAT_FULL : manual_reg; // [R9]
	wire signed [17:0] offset_w = ctrl_reg.add_manual ? $signed(18'(man_w)) : 18'sh0; // [R8] [R12]
	wire signed [17:0] demand_w = ctrl_reg.closed ? (18'(pid_reg) + offset_w) :
		$signed(18'(man_w)); // [R7]
	// Signed compare: a negative demand has to clamp to zero, never saturate
	wire sat_w = demand_w >= $signed(18'(HEAT_FULL)); // [R10]
	wire [13:0] level_w = sat_w ? HEAT_FULL : // [R10]
		(demand_w < 18'sh0) ? 14'h0000 : demand_w[13:0];

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			heat_reg <= '0;
		end else if (tick_d2_reg) begin
			heat_reg.level <= level_w;
			heat_reg.saturated <= sat_w;
		end
	end

	assign heat_o = heat_reg;

	// ---------------- Checks ----------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_err_capture: assert property (tick_w |=> err_reg == $past(err_now_w)) // [R1]
		else $error("error register does not hold setpoint minus feedback");
	a_zero_gain_idle: assert property (tick_d1_reg && gain_reg == 16'h0000 |=> pid_reg == 16'sh0000) // [R2]
		else $error("closed-loop term not zero with zero gain");
	a_integ_clear: assert property (tick_w && !loop_active_w |=> integ_reg == '0) // [R2]
		else $error("integrator kept value while loop inactive");
	a_prop_zero_err: assert property (tick_d1_reg && err_reg == '0 && prev_err_reg == '0 // [R3]
		&& integ_reg == '0 |=> pid_reg == 16'sh0000)
		else $error("zero error without integral gave nonzero output");
	a_integ_hold: assert property (tick_w && err_now_w == '0 && loop_active_w // [R4]
		|=> integ_reg == $past(integ_reg))
		else $error("integrator moved at zero error");
	a_deriv_off: assert property (tick_d1_reg && deriv_time_reg == 16'h0000 |-> dterm_w == '0) // [R12]
		else $error("derivative term active with zero setting");
	a_deriv_history: assert property (tick_w |=> prev_err_reg == $past(err_reg)) // [R11]
		else $error("previous error not shifted on tick");
	a_tick_pipeline: assert property (tick_w |-> ##1 tick_d1_reg ##1 tick_d2_reg ##1 !tick_w) // [R11]
		else $error("sample pipeline out of step");
	a_open_loop_level: assert property (tick_d2_reg && !ctrl_reg.closed // [R7]
		|=> heat_reg.level == $past(man_w))
		else $error("open loop output differs from manual level");
	a_offset_add: assert property (tick_d2_reg && ctrl_reg.closed && ctrl_reg.add_manual // [R8]
		&& pid_reg == 16'sh0000 |=> heat_reg.level == $past(man_w))
		else $error("manual offset not added in closed loop");
	a_heat_limit: assert property (heat_reg.level <= HEAT_FULL) // [R10]
		else $error("heater level above full scale");
	a_sat_full: assert property (heat_reg.saturated |-> heat_reg.level == HEAT_FULL) // [R10]
		else $error("saturation not reported as full scale");
	a_neg_clamp: assert property (tick_d2_reg && ctrl_reg.closed && !ctrl_reg.add_manual // [R10]
		&& pid_reg < 16'sh0000 |=> heat_reg.level == 14'h0000 && !heat_reg.saturated)
		else $error("negative demand not clamped to zero");
	a_open_sat: assert property (tick_d2_reg && !ctrl_reg.closed && manual_reg >= HEAT_FULL // [R10]
		|=> heat_reg.saturated)
		else $error("full manual level not reported as saturated");
	a_manual_none: assert property (tick_d2_reg && ctrl_reg.closed // [R12]
		&& manual_reg == 14'h0000 && pid_reg >= 16'sh0000 && pid_reg < 16'sh2710
		|=> heat_reg.level == $past(pid_reg[13:0]))
		else $error("zero manual level changed the closed-loop output");
	a_integ_off: assert property (tick_d1_reg && integ_rate_reg == 16'h0000 // [R12]
		|-> iterm_w == '0)
		else $error("integral term active with zero setting");
	a_unmapped_err: assert property (setup_w && !mapped_w
		|=> pslverr_o && prdata_o == 32'h0000_0000)
		else $error("unmapped register access not refused");
	a_apb_answer: assert property (setup_w |=> pready_o ##1 !pready_o)
		else $error("register access not answered in one cycle");

	c_closed_sat: cover property (tick_d2_reg && ctrl_reg.closed ##1 heat_reg.saturated);
	c_open_loop: cover property (tick_d2_reg && !ctrl_reg.closed && manual_reg != 14'h0000);
	c_integ_run: cover property (loop_active_w && integ_reg != '0 && integ_rate_reg != 16'h0000);
	c_bad_addr: cover property (access_w && slverr_reg);
endmodule : pid_heater_control_law

// ### verif/temp_plant_model.sv
// Feedback sensor readout and heater driver stand-in for the control law
`timescale 1ns/10ps
module temp_plant_model (
	input wire logic clk_i,
	input wire pid_pkg::heat_out_type heat_i,
	output logic signed [pid_pkg::TEMP_W-1:0] fb_temp_o
);
	import pid_pkg::*;
	logic signed [TEMP_W-1:0] temp_reg = 16'sh4E20;
	logic [HEAT_W-1:0] drive_reg;
	// Reading changes only just after a clock edge, like a real readout update
	task automatic set_temp(input logic signed [TEMP_W-1:0] t);
		@(posedge clk_i);
		temp_reg <= t;
	endtask : set_temp
	// Driver applies full scale whenever the command is flagged saturated
	always_ff @(posedge clk_i) begin
		drive_reg <= heat_i.saturated ? HEAT_FULL : heat_i.level;
	end
	assign fb_temp_o = temp_reg;
endmodule : temp_plant_model

// ### verif/pid_heater_control_law_bench.sv
// Self-checking bench for the heater control law
`timescale 1ns/10ps
module pid_heater_control_law_bench;
	import pid_pkg::*;
	localparam int unsigned TICK = 8;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic signed [TEMP_W-1:0] fb_temp_i;
	heat_out_type heat_o;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic rerr;
	logic [HEAT_W-1:0] lv_a;
	pid_heater_control_law #(.TICK_CYCLES(TICK)) DUT (.clk_i(clk_i), .resetn_i(resetn_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .fb_temp_i(fb_temp_i), .heat_o(heat_o));
	temp_plant_model plant (.clk_i(clk_i), .heat_i(heat_o), .fb_temp_o(fb_temp_i));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic final_report;
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	task automatic expect32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : expect32
	// Setup cycle, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic setreg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : setreg
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		expect32(rd, exp);
	endtask : rdchk
	// Let a few ticks pass so the command settles, then look at it
	task automatic heat_chk(input logic s, input logic [HEAT_W-1:0] lv);
		repeat (4 * TICK) @(posedge clk_i);
		@(negedge clk_i);
		expect32({17'h0, heat_o}, {17'h0, s, lv});
		expect32({18'h0, plant.drive_reg}, {18'h0, lv});
	endtask : heat_chk
	task automatic wait_change;
		logic [HEAT_W-1:0] old;
		old = heat_o.level;
		do @(negedge clk_i); while (heat_o.level === old);
	endtask : wait_change
	task automatic t_reset;
		heat_chk(1'b0, 14'h0000);
		rdchk(CTRL_OFS, 32'h0);
		rdchk(8'h24, 32'h0);
		expect32({31'h0, rerr}, 32'h1);
	endtask : t_reset
	task automatic t_open;
		setreg(MANUAL_OFS, 32'h1388);
		heat_chk(1'b0, 14'h1388);
		plant.set_temp(16'sh03E8);
		heat_chk(1'b0, 14'h1388);
		setreg(MANUAL_OFS, 32'h2EE0);
		heat_chk(1'b1, 14'h2710);
		setreg(MANUAL_OFS, 32'h0);
		plant.set_temp(16'sh4E20);
	endtask : t_open
	task automatic t_prop;
		setreg(CTRL_OFS, 32'h1);
		setreg(SETPOINT_OFS, 32'h53FC);
		heat_chk(1'b0, 14'h0000);
		rdchk(STATUS_OFS, 32'h0);
		setreg(GAIN_OFS, 32'h200);
		heat_chk(1'b0, 14'h0BB8);
		rdchk(STATUS_OFS, 32'h2);
		setreg(SETPOINT_OFS, 32'h4E20);
		heat_chk(1'b0, 14'h0000);
		setreg(SETPOINT_OFS, 32'h4A38);
		heat_chk(1'b0, 14'h0000);
		setreg(SETPOINT_OFS, 32'h6D60);
		heat_chk(1'b1, 14'h2710);
		rdchk(STATUS_OFS, 32'h3);
		rdchk(HEAT_OFS, 32'h2710);
		rdchk(ERROR_OFS, 32'h1F40);
	endtask : t_prop
	task automatic t_offset;
		setreg(GAIN_OFS, 32'h100);
		setreg(SETPOINT_OFS, 32'h5014);
		setreg(CTRL_OFS, 32'h3);
		heat_chk(1'b0, 14'h01F4);
		setreg(MANUAL_OFS, 32'h7D0);
		heat_chk(1'b0, 14'h09C4);
		setreg(MANUAL_OFS, 32'h0);
		setreg(CTRL_OFS, 32'h1);
		setreg(GAIN_OFS, 32'h0);
	endtask : t_offset
	task automatic t_integ;
		setreg(INTEG_RATE_OFS, 32'hA);
		setreg(SETPOINT_OFS, 32'h5208);
		heat_chk(1'b0, 14'h0000);
		setreg(GAIN_OFS, 32'h100);
		wait_change();
		repeat (TICK / 2) @(negedge clk_i);
		lv_a = heat_o.level;
		repeat (TICK) @(negedge clk_i);
		expect32({18'h0, heat_o.level}, {18'h0, lv_a + 14'h0001});
		setreg(SETPOINT_OFS, 32'h4E20);
		repeat (4 * TICK) @(negedge clk_i);
		lv_a = heat_o.level;
		expect32({31'h0, heat_o.saturated || lv_a == 14'h0000 || lv_a >= 14'h03E8}, 32'h0);
		repeat (TICK) @(negedge clk_i);
		expect32({18'h0, heat_o.level}, {18'h0, lv_a});
		setreg(INTEG_RATE_OFS, 32'h0);
		heat_chk(1'b0, 14'h0000);
		setreg(GAIN_OFS, 32'h0);
	endtask : t_integ
	task automatic t_deriv;
		setreg(DERIV_TIME_OFS, 32'h1);
		setreg(GAIN_OFS, 32'h100);
		heat_chk(1'b0, 14'h0000);
		setreg(SETPOINT_OFS, 32'h4E84);
		wait_change();
		expect32({18'h0, heat_o.level}, 32'h44C);
		repeat (TICK) @(negedge clk_i);
		expect32({18'h0, heat_o.level}, 32'h64);
	endtask : t_deriv
	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_open();
		t_prop();
		t_offset();
		t_integ();
		t_deriv();
		final_report();
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			$display("mismatch at %0t: run did not finish", $time);
			final_report();
		end
	end
endmodule : pid_heater_control_law_bench
